/* File: dv/safety_far_side_model.sv */
// Far-side model: mechanical safety contacts that chatter before settling.
// Assumes the bench sets the wanted contact levels on target.
`timescale 1ns/1ps

module safety_far_side_model
(
    input  wire logic                      pclk,
    input  wire safety_io_pkg::safety_in_s target,
    output safety_io_pkg::safety_in_s      contacts
);
    import safety_io_pkg::*;
    safety_in_s contact_reg = '0;
    safety_in_s diff_reg    = '0;
    logic [2:0] chatter_reg = 3'h0;

    // Each change chatters an even number of times, so it ends on the wanted level.
    // Contacts feed only this unit; no stop output is ever looped back here.
    always_ff @(posedge pclk)
    begin
        if (chatter_reg != 3'h0)
        begin
            contact_reg <= contact_reg ^ diff_reg;
            chatter_reg <= chatter_reg - 3'h1;
        end
        else if (target !== contact_reg)
        begin
            diff_reg    <= target ^ contact_reg;
            contact_reg <= target;
            chatter_reg <= 3'h4;
        end
    end

    assign contacts = contact_reg;
endmodule : safety_far_side_model

/* File: dv/safety_io_status_logic_tb.sv */
// Testbench for the safety I/O status logic: APB master, contact model, checks.
// Assumes the design, its package and defines header are compiled first.
`timescale 1ns/1ps
`include "safety_io_defines.svh"

module safety_io_status_logic_tb;
    import safety_io_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    safety_in_s  target;
    safety_in_s  contacts;
    safety_out_s so;
    logic        force_mode;
    logic        verify_mode;
    logic        motion_permit;
    logic        irq;
    logic [31:0] rdata;
    logic        rerr;
    int          num_errors;
    int          cmp_count;

    safety_io_status_logic safety_io_status_logic_i
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .safety_in(contacts), .safety_out(so),
        .force_mode(force_mode), .verify_mode(verify_mode),
        .motion_permit(motion_permit), .irq(irq)
    );

    safety_far_side_model safety_far_side_model_i
    (
        .pclk(pclk), .target(target), .contacts(contacts)
    );

    // Free-running 125 MHz clock.
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_word

    task automatic chk_bit(input string name, input logic exp, input logic got);
        chk_word(name, {31'h0, exp}, {31'h0, got});
    endtask : chk_bit

    // One APB transfer; the wait on pready is bounded so a hang ends the run.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            num_errors++;
            wrap_up();
        end
        rdata = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Sets the contacts and waits out chatter, synchronisers and the filter.
    task automatic put(input safety_in_s v);
        @(posedge pclk);
        target <= v;
        repeat (150) @(posedge pclk);
    endtask : put

    task automatic t_reset();
        chk_word("outputs", 32'h44, {24'h0, so});
        chk_bit("irq", 1'b0, irq);
        apb(1'b0, `OFF_CTRL, 32'h0);
        chk_word("ctrl", `CTRL_RESET, rdata);
        apb(1'b0, `OFF_IRQ_EN, 32'h0);
        chk_word("irq_en", `IRQ_EN_RESET, rdata);
        $display("reset test done");
    endtask : t_reset

    task automatic t_modes();
        put(4'h8);
        chk_bit("verify", 1'b1, verify_mode);
        chk_bit("permit", 1'b0, motion_permit);
        put(4'hC);
        chk_bit("permit", 1'b1, motion_permit);
        put(4'h2);
        chk_bit("verify", 1'b0, verify_mode);
        chk_bit("permit", 1'b1, motion_permit);
        chk_bit("force", 1'b1, force_mode);
        put(4'h0);
        chk_bit("force", 1'b0, force_mode);
        $display("mode test done");
    endtask : t_modes

    task automatic t_move();
        apb(1'b1, `OFF_CTRL, 32'hF);
        apb(1'b0, `OFF_CTRL, 32'h0);
        chk_word("ctrl", 32'hF, rdata);
        chk_word("outputs", 32'h6B, {24'h0, so});
        apb(1'b1, `OFF_CTRL, 32'h9);
        repeat (4) @(posedge pclk);
        chk_word("outputs", 32'h65, {24'h0, so});
        $display("move test done");
    endtask : t_move

    // Losing the enabling device in verification mode pauses, regaining resumes.
    task automatic t_pause();
        put(4'hC);
        chk_bit("moving", 1'b1, so.moving);
        put(4'h8);
        chk_bit("moving", 1'b0, so.moving);
        chk_bit("permit", 1'b0, motion_permit);
        put(4'hC);
        chk_bit("moving", 1'b1, so.moving);
        put(4'h0);
        $display("pause test done");
    endtask : t_pause

    // A stop pulse shorter than the filter time must leave motion alone.
    task automatic t_glitch();
        @(posedge pclk);
        target <= 4'h1;
        repeat (60) @(posedge pclk);
        target <= 4'h0;
        repeat (150) @(posedge pclk);
        chk_bit("not_stopping", 1'b0, so.not_stopping);
        chk_bit("moving", 1'b1, so.moving);
        $display("glitch test done");
    endtask : t_glitch

    task automatic t_stop();
        apb(1'b1, `OFF_IRQ_CLR, 32'hF);
        apb(1'b1, `OFF_IRQ_EN, 32'h1);
        put(4'h1);
        chk_word("outputs", 32'h55, {24'h0, so});
        chk_bit("irq", 1'b0, irq);
        apb(1'b1, `OFF_CTRL, 32'h29);
        repeat (4) @(posedge pclk);
        chk_word("outputs", 32'h85, {24'h0, so});
        chk_bit("irq", 1'b1, irq);
        apb(1'b0, `OFF_IRQ_STAT, 32'h0);
        chk_word("irq_stat", 32'h3, rdata & 32'hF);
        apb(1'b1, `OFF_IRQ_EN, 32'h0);
        repeat (2) @(posedge pclk);
        chk_bit("irq masked", 1'b0, irq);
        apb(1'b1, `OFF_IRQ_CLR, 32'hF);
        apb(1'b0, `OFF_IRQ_STAT, 32'h0);
        chk_word("irq_stat", 32'h0, rdata & 32'hF);
        put(4'h0);
        chk_word("outputs", 32'h85, {24'h0, so});
        apb(1'b1, `OFF_CTRL, 32'h40);
        repeat (4) @(posedge pclk);
        chk_word("outputs", 32'h44, {24'h0, so});
        // Idle, normal mode, nothing filtered high: only the permit bit is set.
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk_word("status", 32'h8, rdata);
        $display("stop test done");
    endtask : t_stop

    task automatic t_unmapped();
        apb(1'b1, 12'h020, 32'hF);
        chk_bit("slverr", 1'b1, rerr);
        apb(1'b0, 12'h020, 32'h0);
        chk_bit("slverr", 1'b1, rerr);
        chk_word("unmapped", 32'h0, rdata);
        apb(1'b0, `OFF_CTRL, 32'h0);
        chk_bit("slverr", 1'b0, rerr);
        chk_word("ctrl", 32'h40, rdata);
        $display("unmapped test done");
    endtask : t_unmapped

    // Reset for six cycles, then the scenarios in order.
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        target = '0;
        num_errors = 0;
        cmp_count = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_modes();
        t_move();
        t_pause();
        t_glitch();
        t_stop();
        t_unmapped();
        wrap_up();
    end
endmodule : safety_io_status_logic_tb

/* File: logic/safety_io_defines.svh */
// Timing counts and register map for the safety I/O status logic.
// Assumes a 125 MHz pclk and the APB register layout below.
`ifndef SAFETY_IO_DEFINES_SVH
`define SAFETY_IO_DEFINES_SVH

`define CLK_PERIOD_NS       8
`define DEBOUNCE_TIME_NS    1000
`define DEBOUNCE_CYCLES     (`DEBOUNCE_TIME_NS / `CLK_PERIOD_NS)
`define DEB_CNT_W           8
`define OFF_CTRL            12'h000
`define OFF_STATUS          12'h004
`define OFF_IRQ_STAT        12'h008
`define OFF_IRQ_EN          12'h00C
`define OFF_IRQ_CLR         12'h010
`define CTRL_RESET          32'h0000_0000
`define IRQ_EN_RESET        4'h0
`define CTRL_MOVE_REQ_BIT   0
`define CTRL_REDUCED_BIT    1
`define CTRL_ERROR_BIT      2
`define CTRL_SW_RUN_BIT     3
`define CTRL_ESTOP_BIT      4
`define CTRL_STOPPED_BIT    5
`define CTRL_ESTOP_CLR_BIT  6
`define IRQ_W               4
`define IRQ_ESTOP_BIT       0
`define IRQ_SYSSTOP_BIT     1
`define IRQ_PAUSE_BIT       2
`define IRQ_MODE_BIT        3

`endif

/* File: logic/safety_io_pkg.sv */
// Types shared by the safety I/O status logic.
// Assumes the defines header is compiled alongside.
package safety_io_pkg;

    typedef enum logic [1:0]
    {
        ST_IDLE,
        ST_MOVING,
        ST_STOPPING,
        ST_ESTOP
    } motion_e;

    typedef struct packed
    {
        logic mode_sel_b;
        logic enable_dev;
        logic force_en;
        logic sys_stop;
    } safety_in_s;

    typedef struct packed
    {
        logic estop_no;
        logic estop_nc;
        logic moving;
        logic not_stopping;
        logic reduced;
        logic non_reduced;
        logic sys_error;
        logic sw_running;
    } safety_out_s;

endpackage : safety_io_pkg

/* File: logic/safety_io_status_logic.sv */
// Safety I/O status logic: debounced safety inputs, motion state and status outputs.
// Assumes an APB master on pclk; safety inputs arrive asynchronous from contacts.
//
// How it works
// - Selector in position A gives normal mode with no enabling-device qualification.
// - Selector in position B gives verification mode.
// - In verification mode motion is permitted only while the enabling device is valid.
// - In verification mode a lost enabling device pauses motion in the very next cycle.
// - An asserted force-control enable input puts the robot in force-control mode.
// - An asserted system-stop input causes a category 1 stop, as for emergency stop.
// - Stop sharing is not one-way: the system-stop input leads to ST_ESTOP and so drives this unit's emergency-stop outputs.
// - The normally-open emergency-stop output is high exactly while in emergency stop.
// - The moving output is high exactly while the robot moves normally.
// - The not-stopping output is high from a stop request until motion has ceased.
// - The reduced-mode output is high while the robot is in reduced mode.
// - The non-reduced-mode output is the complement of the reduced-mode output.
// - The system-error output is high while an error alarm is active.
// - The normally-closed emergency-stop output is always the inverse of the normally-open one.
// - The software-running output is high while the controller software runs.
`timescale 1ns/1ps
`include "safety_io_defines.svh"

module safety_io_status_logic
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire safety_io_pkg::safety_in_s safety_in,
    output safety_io_pkg::safety_out_s     safety_out,
    output logic                           force_mode,
    output logic                           verify_mode,
    output logic                           motion_permit,
    output logic                           irq
);
    import safety_io_pkg::*;

    localparam int unsigned DEB_MAX = `DEBOUNCE_CYCLES;

    logic [3:0]            sync1_reg;
    logic [3:0]            sync2_reg;
    logic [3:0]            deb_reg;
    logic [`DEB_CNT_W-1:0] deb_cnt_reg [4];
    logic [31:0]           ctrl_reg;
    logic [`IRQ_W-1:0]     irq_stat_reg;
    logic [`IRQ_W-1:0]     irq_en_reg;
    logic [`IRQ_W-1:0]     irq_ev;
    motion_e               state_reg;
    motion_e               state_next;
    logic                  sys_stop_d_reg;
    logic                  verify_d_reg;
    logic                  pause_d_reg;
    logic                  stop_req;
    logic                  wr_en;
    logic                  rd_en;
    logic                  addr_ok;

    // Two flip-flops per input; only the second stage is ever looked at.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end
        else
        begin
            sync1_reg <= safety_in;
            sync2_reg <= sync1_reg;
        end
    end

    // A level is accepted only after it has stood still for the whole filter time.
    // This trades a microsecond of latency for immunity to contact bounce.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            deb_reg <= 4'h0;
            for (int i = 0; i < 4; i++)
                deb_cnt_reg[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (sync2_reg[i] == deb_reg[i])
                    deb_cnt_reg[i] <= '0;
                else if (deb_cnt_reg[i] == `DEB_CNT_W'(DEB_MAX - 1))
                begin
                    deb_reg[i]     <= sync2_reg[i];
                    deb_cnt_reg[i] <= '0;
                end
                else
                    deb_cnt_reg[i] <= deb_cnt_reg[i] + `DEB_CNT_W'(1);
            end
        end
    end

    // Filtered input bits, in struct order: mode, enable, force, stop.
    assign verify_mode   = deb_reg[3];
    assign force_mode    = deb_reg[1];
    // Permission is combinational so that loss of the enable pauses at once.
    assign motion_permit = !verify_mode || deb_reg[2];
    assign stop_req      = deb_reg[0] || ctrl_reg[`CTRL_ESTOP_BIT];

    // Next motion state. The system-stop input feeds this unit's own stop,
    // and through ST_ESTOP it also reaches the emergency-stop outputs.
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (stop_req)
                    state_next = ST_ESTOP;
                else if (ctrl_reg[`CTRL_MOVE_REQ_BIT] && motion_permit)
                    state_next = ST_MOVING;
            end
            ST_MOVING:
            begin
                if (stop_req)
                    state_next = ST_STOPPING;
                else if (!motion_permit)
                    state_next = ST_IDLE;
                else if (!ctrl_reg[`CTRL_MOVE_REQ_BIT])
                    state_next = ST_IDLE;
            end
            ST_STOPPING:
            begin
                if (ctrl_reg[`CTRL_STOPPED_BIT])
                    state_next = ST_ESTOP;
            end
            ST_ESTOP:
            begin
                if (!stop_req && ctrl_reg[`CTRL_ESTOP_CLR_BIT])
                    state_next = ST_IDLE;
            end
            default:
                state_next = ST_ESTOP;
        endcase
    end

    // The motion state register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    // Status outputs come straight from flip-flops.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            safety_out <= 8'h44; // estop_nc and non_reduced high, all else low.
        else
        begin
            safety_out.estop_no     <= (state_next == ST_ESTOP);
            safety_out.estop_nc     <= !(state_next == ST_ESTOP);
            safety_out.moving       <= (state_next == ST_MOVING);
            safety_out.not_stopping <= (state_next == ST_STOPPING);
            safety_out.reduced      <= ctrl_reg[`CTRL_REDUCED_BIT];
            safety_out.non_reduced  <= !ctrl_reg[`CTRL_REDUCED_BIT];
            safety_out.sys_error    <= ctrl_reg[`CTRL_ERROR_BIT];
            safety_out.sw_running   <= ctrl_reg[`CTRL_SW_RUN_BIT];
        end
    end

    // APB decode: zero wait states, unmapped addresses answer with pslverr.
    assign addr_ok = (paddr == `OFF_CTRL) || (paddr == `OFF_STATUS) ||
                     (paddr == `OFF_IRQ_STAT) || (paddr == `OFF_IRQ_EN) ||
                     (paddr == `OFF_IRQ_CLR);
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // Software-written control and interrupt enable registers.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg   <= `CTRL_RESET;
            irq_en_reg <= `IRQ_EN_RESET;
        end
        else if (wr_en && paddr == `OFF_CTRL)
            ctrl_reg <= pwdata;
        else if (wr_en && paddr == `OFF_IRQ_EN)
            irq_en_reg <= pwdata[`IRQ_W-1:0];
    end

    // Read data is registered in the setup cycle so it stands through the access.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (rd_en)
        begin
            case (paddr)
                `OFF_CTRL:     prdata <= ctrl_reg;
                `OFF_STATUS:   prdata <= {20'h0, state_reg, deb_reg, 2'h0, motion_permit,
                                          verify_mode, force_mode, safety_out.estop_no};
                `OFF_IRQ_STAT: prdata <= {28'h0, irq_stat_reg};
                `OFF_IRQ_EN:   prdata <= {28'h0, irq_en_reg};
                default:       prdata <= 32'h0;
            endcase
        end
    end

    // Event edges that feed the sticky interrupt bits.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sys_stop_d_reg <= 1'b0;
            verify_d_reg   <= 1'b0;
            pause_d_reg    <= 1'b0;
        end
        else
        begin
            sys_stop_d_reg <= deb_reg[0];
            verify_d_reg   <= verify_mode;
            pause_d_reg    <= motion_permit;
        end
    end

    assign irq_ev[`IRQ_ESTOP_BIT]   = (state_next == ST_ESTOP) && (state_reg != ST_ESTOP);
    assign irq_ev[`IRQ_SYSSTOP_BIT] = deb_reg[0] && !sys_stop_d_reg;
    assign irq_ev[`IRQ_PAUSE_BIT]   = pause_d_reg && !motion_permit;
    assign irq_ev[`IRQ_MODE_BIT]    = verify_mode != verify_d_reg;

    // Sticky status: a new event in the clearing cycle wins over the clear.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat_reg <= '0;
        else if (wr_en && paddr == `OFF_IRQ_CLR)
            irq_stat_reg <= (irq_stat_reg & ~pwdata[`IRQ_W-1:0]) | irq_ev;
        else
            irq_stat_reg <= irq_stat_reg | irq_ev;
    end

    assign irq = |(irq_stat_reg & irq_en_reg);

    // Checks on the logic above.
    a_nc_inverse_no: assert property (@(posedge pclk) disable iff (!presetn)
        safety_out.estop_nc == !safety_out.estop_no)
        else $error("Normally closed stop output is not the inverse.");
    a_reduced_compl: assert property (@(posedge pclk) disable iff (!presetn)
        safety_out.reduced != safety_out.non_reduced)
        else $error("Reduced outputs are not complementary.");
    a_pause_at_once: assert property (@(posedge pclk) disable iff (!presetn)
        (verify_mode && !deb_reg[2]) |=> !safety_out.moving)
        else $error("Motion not paused when enabling device lost.");
    a_normal_no_enable: assert property (@(posedge pclk) disable iff (!presetn)
        !verify_mode |-> motion_permit)
        else $error("Normal mode gated by enabling device.");
    a_verify_permit: assert property (@(posedge pclk) disable iff (!presetn)
        verify_mode |-> (motion_permit == deb_reg[2]))
        else $error("Verification permit mismatch.");
    a_sys_stop_halts: assert property (@(posedge pclk) disable iff (!presetn)
        (deb_reg[0] && state_reg == ST_IDLE) |=> safety_out.estop_no)
        else $error("System stop did not stop the unit.");
    a_stop_decel: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == ST_MOVING && stop_req) |=> safety_out.not_stopping)
        else $error("Not stopping output missing during deceleration.");
    a_moving_flag: assert property (@(posedge pclk) disable iff (!presetn)
        safety_out.moving == (state_reg == ST_MOVING))
        else $error("Moving output without moving state.");
    a_error_follow: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_reg[`CTRL_ERROR_BIT] |=> safety_out.sys_error)
        else $error("System error output does not follow the alarm.");
    a_sw_run_follow: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_reg[`CTRL_SW_RUN_BIT] |=> safety_out.sw_running)
        else $error("Software running output does not follow.");
    a_force_follow: assert property (@(posedge pclk) disable iff (!presetn)
        force_mode == deb_reg[1])
        else $error("Force mode does not follow its input.");

endmodule : safety_io_status_logic
